/* File: hw/lsmc_defines.vh */
// constants for the bus mode controller: timing, offsets, fields
`ifndef LSMC_DEFINES_VH
`define LSMC_DEFINES_VH

`define LSMC_CLK_MHZ        50
// times in their own units, cycle counts derived from the clock rate
`define LSMC_T_RESET_US     10000
`define LSMC_T_TXDOM_US     6000
`define LSMC_T_LEAD_US      49000
`define LSMC_T_WDPER_US     20500
`define LSMC_T_NRESP_US     1960
`define LSMC_T_BUSWK_US     100
`define LSMC_T_LOCWK_US     200
`define LSMC_T_MSW_NS       3200
// counts of the times above at 50 mhz, sized to their counters
`define LSMC_CYC_RESET      24'h07a120
`define LSMC_CYC_TXDOM      24'h0493e0
`define LSMC_CYC_LEAD       24'h256250
`define LSMC_CYC_WDPER      24'h0fa3e8
`define LSMC_CYC_NRESP      24'h017ed0
`define LSMC_CYC_BUSWK      24'h001388
`define LSMC_CYC_LOCWK      24'h002710
`define LSMC_CYC_MSW        8'ha0

// register offsets (byte addresses)
`define LSMC_OFS_CTRL       12'h000
`define LSMC_OFS_STAT       12'h004
// control fields
`define LSMC_CTRL_HOSTSUP   0
`define LSMC_CTRL_LWAKEEN   1
`define LSMC_CTRL_RST       2'h3
// status fields
`define LSMC_ST_MODE_LO     0
`define LSMC_ST_WAKEREQ     6
`define LSMC_ST_WAKELOC     7
`define LSMC_ST_NRES        8
`define LSMC_ST_TXDTO       9
`define LSMC_ST_HOLD        10
`define LSMC_ST_WDON        11

`endif

/* File: hw/lsmc_low_filter.v */
// low-level qualifier: a falling edge (or a low at enable when ARM0 is set) then a low held for a count
`timescale 1ns/1ps
`include "lsmc_defines.vh"
module lsmc_low_filter #(
   parameter [23:0] CNT  = 24'd1,
   parameter        ARM0 = 1'b0
) (
   input  wire clk,
   input  wire rst_n,
   input  wire enable,
   input  wire lvl,
   output wire hit
);
   reg        armed_r;
   reg [23:0] cnt_r;
   reg        hit_r;

   // arming on a high level means a stuck-low line never qualifies, unless ARM0 is set
   always @(posedge clk) begin
      if (!rst_n || !enable) begin
         armed_r <= ARM0;
         cnt_r   <= 24'h0;
         hit_r   <= 1'b0;
      end else if (lvl) begin
         armed_r <= 1'b1;
         cnt_r   <= 24'h0;
         hit_r   <= 1'b0;
      end else if (armed_r) begin
         if (cnt_r >= CNT - 24'h1)
            hit_r <= 1'b1;
         else
            cnt_r <= cnt_r + 24'h1;
      end
   end

   assign hit = hit_r;
endmodule // lsmc_low_filter

/* File: hw/lsmc_trig_watch.v */
// trigger supervisor: lead time, then period; expiry gives a reset pulse
`timescale 1ns/1ps
`include "lsmc_defines.vh"
module lsmc_trig_watch #(
   parameter [23:0] LEAD   = 24'd1,
   parameter [23:0] PERIOD = 24'd1,
   parameter [23:0] PULSE  = 24'd1
) (
   input  wire clk,
   input  wire rst_n,
   input  wire enable,
   input  wire trig,
   output wire rstLow
);
   reg [23:0] cnt_r;
   reg        pulse_r;
   reg        enD_r;

   // window shape is simplified: any trigger outside the reset pulse restarts the period
   always @(posedge clk) begin
      if (!rst_n || !enable) begin
         cnt_r   <= 24'h0;
         pulse_r <= 1'b0;
         enD_r   <= 1'b0;
      end else begin
         enD_r <= 1'b1;
         if (!enD_r) begin
            cnt_r <= LEAD - 24'h1;
         end else if (pulse_r) begin
            if (cnt_r == 24'h0) begin
               pulse_r <= 1'b0;
               cnt_r   <= LEAD - 24'h1;
            end else begin
               cnt_r <= cnt_r - 24'h1;
            end
         end else if (trig) begin
            cnt_r <= PERIOD - 24'h1;
         end else if (cnt_r == 24'h0) begin
            pulse_r <= 1'b1;
            cnt_r   <= PULSE - 24'h1;
         end else begin
            cnt_r <= cnt_r - 24'h1;
         end
      end
   end

   assign rstLow = pulse_r;
endmodule // lsmc_trig_watch

/* File: hw/lsmc_mode_ctrl.v */
// operating-mode controller of the bus transceiver and supply chip
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "lsmc_defines.vh"
module lsmc_mode_ctrl #(
   parameter [23:0] RESET_CYC = `LSMC_CYC_RESET,
   parameter [23:0] TXDOM_CYC = `LSMC_CYC_TXDOM,
   parameter [23:0] LEAD_CYC  = `LSMC_CYC_LEAD,
   parameter [23:0] WDPER_CYC = `LSMC_CYC_WDPER,
   parameter [23:0] NRESP_CYC = `LSMC_CYC_NRESP,
   parameter [23:0] BUSWK_CYC = `LSMC_CYC_BUSWK,
   parameter [23:0] LOCWK_CYC = `LSMC_CYC_LOCWK
) (
   input  wire        clk,
   input  wire        rst_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // pins and analog monitors
   input  wire        enPin,
   input  wire        txdIn,
   output wire        txdOut,
   output reg         txdOe_n,
   output reg         txdWeakPd,
   input  wire        busRx,
   output reg         busDrive,
   output reg         rxdOut,
   input  wire        wakePin_n,
   input  wire        debugSel,
   input  wire        trigger_rise_in,
   input  wire        trigger_fall_in,
   input  wire        vsPowerOk,
   input  wire        vddUnder,
   output reg         nresOut_n,
   output reg         regOn,
   output reg         regLowTol,
   output reg         termOn,
   output reg         wdActive
);
   localparam [5:0] ST_UNPWR = 6'h01;
   localparam [5:0] ST_PRE   = 6'h02;
   localparam [5:0] ST_NORM  = 6'h04;
   localparam [5:0] ST_SEL   = 6'h08;
   localparam [5:0] ST_SIL   = 6'h10;
   localparam [5:0] ST_SLP   = 6'h20;
   localparam [7:0] MSW_CYC  = `LSMC_CYC_MSW;

   // two-flop synchronisers for every pin input
   reg  [8:0] syncA_r;
   reg  [8:0] syncB_r;
   reg  [1:0] trigD_r;
   wire [8:0] rawIn;
   assign rawIn = {vddUnder, vsPowerOk, trigger_fall_in, trigger_rise_in,
                   debugSel, wakePin_n, busRx, txdIn, enPin};
   // reset to idle pin levels so no false edge follows reset
   always @(posedge clk) begin
      if (!rst_n) begin
         syncA_r <= 9'h04e;
         syncB_r <= 9'h04e;
         trigD_r <= 2'h0;
      end else begin
         syncA_r <= rawIn;
         syncB_r <= syncA_r;
         trigD_r <= syncB_r[6:5];
      end
   end
   wire enS    = syncB_r[0];
   wire txdS   = syncB_r[1];
   wire busS   = syncB_r[2];
   wire wakeS  = syncB_r[3];
   wire dbgS   = syncB_r[4];
   wire vsOkS  = syncB_r[7];
   wire uvS    = syncB_r[8];
   wire trigEv = (syncB_r[5] & ~trigD_r[0]) | (~syncB_r[6] & trigD_r[1]);

   // software control
   reg  [1:0]  ctrl_r;
   reg  [5:0]  state_r;
   reg  [5:0]  state_nxt;
   reg  [23:0] resetCnt_r;
   reg  [7:0]  mswCnt_r;
   reg         sleepPick_r;
   reg         wakeReq_r;
   reg         wakeLoc_r;
   wire        busWake;
   wire        locWake;
   wire        txdTimeout;
   wire        wdRstLow;
   wire        hostSup = ctrl_r[`LSMC_CTRL_HOSTSUP];
   wire        lwakeEn = ctrl_r[`LSMC_CTRL_LWAKEEN];
   wire        resetHold = (resetCnt_r != 24'h0);
   wire        quiet = (state_r == ST_SIL) || (state_r == ST_SLP);
   wire        anyWake = busWake | locWake;

   lsmc_low_filter #(
      .CNT  (BUSWK_CYC),
      .ARM0 (1'b0)
   ) uBusWake (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (quiet),
      .lvl    (busS),
      .hit    (busWake)
   );

   lsmc_low_filter #(
      .CNT  (LOCWK_CYC),
      .ARM0 (1'b0)
   ) uLocWake (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (quiet & lwakeEn),
      .lvl    (wakeS),
      .hit    (locWake)
   );

   lsmc_low_filter #(
      .CNT  (TXDOM_CYC),
      .ARM0 (1'b1)
   ) uTxdTo (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (state_r == ST_NORM),
      .lvl    (txdS),
      .hit    (txdTimeout)
   );

   wire wdEn = ~dbgS & ~resetHold &
               ((state_r == ST_PRE) || (state_r == ST_NORM));

   lsmc_trig_watch #(
      .LEAD   (LEAD_CYC),
      .PERIOD (WDPER_CYC),
      .PULSE  (NRESP_CYC)
   ) uWatch (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (wdEn),
      .trig   (trigEv),
      .rstLow (wdRstLow)
   );

   // mode transitions
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_UNPWR: begin
            if (vsOkS)
               state_nxt = ST_PRE;
         end
         ST_PRE: begin
            if (enS && !resetHold && !uvS)
               state_nxt = ST_NORM;
         end
         ST_NORM: begin
            if (uvS)
               state_nxt = ST_PRE;
            else if (!enS)
               state_nxt = ST_SEL;
         end
         ST_SEL: begin
            if (uvS)
               state_nxt = ST_PRE;
            else if (enS)
               state_nxt = ST_NORM;
            else if (mswCnt_r == 8'h0)
               state_nxt = (sleepPick_r || !txdS) ? ST_SLP : ST_SIL;
         end
         ST_SIL: begin
            if (uvS || anyWake)
               state_nxt = ST_PRE;
            else if (enS)
               state_nxt = ST_NORM;
         end
         ST_SLP: begin
            if (anyWake)
               state_nxt = ST_PRE;
            else if (enS && !hostSup)
               state_nxt = ST_NORM;
         end
         default: state_nxt = ST_UNPWR;
      endcase
      if (!vsOkS)
         state_nxt = ST_UNPWR;
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_r     <= ST_UNPWR;
         resetCnt_r  <= 24'h0;
         mswCnt_r    <= 8'h0;
         sleepPick_r <= 1'b0;
         wakeReq_r   <= 1'b0;
         wakeLoc_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt == ST_UNPWR)
            resetCnt_r <= 24'h0;
         else if ((state_r == ST_UNPWR) || (state_r == ST_SLP &&
                  state_nxt != ST_SLP) || (uvS && !quiet))
            resetCnt_r <= RESET_CYC;
         else if (resetHold)
            resetCnt_r <= resetCnt_r - 24'h1;
         if (state_nxt == ST_SEL && state_r != ST_SEL) begin
            mswCnt_r    <= MSW_CYC;
            sleepPick_r <= ~txdS;
         end else if (state_r == ST_SEL) begin
            if (mswCnt_r != 8'h0)
               mswCnt_r <= mswCnt_r - 8'h1;
            if (!txdS)
               sleepPick_r <= 1'b1;
         end
         if (quiet && anyWake) begin
            wakeReq_r <= 1'b1;
            wakeLoc_r <= locWake;
         end else if (enS || state_nxt == ST_UNPWR) begin
            wakeReq_r <= 1'b0;
            wakeLoc_r <= 1'b0;
         end
      end
   end

   // registered pin outputs
   always @(posedge clk) begin
      if (!rst_n) begin
         busDrive  <= 1'b0;
         rxdOut    <= 1'b0;
         nresOut_n <= 1'b0;
         regOn     <= 1'b0;
         regLowTol <= 1'b0;
         termOn    <= 1'b0;
         wdActive  <= 1'b0;
         txdOe_n   <= 1'b1;
         txdWeakPd <= 1'b0;
      end else begin
         busDrive  <= (state_r == ST_NORM) & ~txdS & ~txdTimeout;
         case (state_r)
            ST_NORM, ST_SEL: rxdOut <= busS;
            ST_PRE:          rxdOut <= ~wakeReq_r;
            ST_SIL:          rxdOut <= 1'b1;
            default:         rxdOut <= 1'b0;
         endcase
         // silent keeps reset high until undervoltage
         // host timers keep running in silent, so no reset there
         nresOut_n <= ~resetHold & ~wdRstLow & ~uvS &
                      (state_r != ST_SLP) & (state_r != ST_UNPWR);
         regOn     <= (state_r != ST_UNPWR) && (state_r != ST_SLP);
         regLowTol <= (state_r == ST_SIL);
         termOn    <= (state_r == ST_PRE) || (state_r == ST_NORM) ||
                      (state_r == ST_SEL);
         wdActive  <= wdEn;
         txdOe_n   <= ~((state_r == ST_PRE) & wakeReq_r & wakeLoc_r);
         txdWeakPd <= (state_r == ST_PRE) & wakeReq_r & ~wakeLoc_r;
      end
   end
   // strong pull-down drives a constant low
   assign txdOut = 1'b0;

   // apb slave, no wait states
   // read data latched at setup, so it stands through the access
   wire apbSetup = psel & ~penable;
   wire apbWr    = psel & penable & pwrite;
   wire hitCtrl  = (paddr == `LSMC_OFS_CTRL);
   wire hitStat  = (paddr == `LSMC_OFS_STAT);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hitCtrl & ~hitStat;

   always @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r <= `LSMC_CTRL_RST;
         prdata <= 32'h0;
      end else begin
         if (apbWr && hitCtrl)
            ctrl_r <= pwdata[1:0];
         if (apbSetup && !pwrite) begin
            if (hitCtrl)
               prdata <= {30'h0, ctrl_r};
            else if (hitStat)
               prdata <= {20'h0, wdEn, resetHold, txdTimeout,
                          nresOut_n, wakeLoc_r, wakeReq_r, state_r};
            else
               prdata <= 32'h0;
         end
      end
   end
endmodule // lsmc_mode_ctrl

/* File: tb/lsmc_mode_ctrl_properties.sv */
// pin-level checker for the mode controller
`timescale 1ns/1ps
module lsmc_mode_ctrl_properties #(
   parameter [23:0] TXDOM_CYC = 24'h000028,
   parameter [23:0] LEAD_CYC  = 24'h0000c8
) (
   input wire clk,
   input wire rst_n,
   input wire enPin,
   input wire txdIn,
   input wire txdOe_n,
   input wire txdWeakPd,
   input wire busDrive,
   input wire rxdOut,
   input wire debugSel,
   input wire trigger_rise_in,
   input wire trigger_fall_in,
   input wire vddUnder,
   input wire nresOut_n,
   input wire regOn,
   input wire regLowTol,
   input wire termOn,
   input wire wdActive
);
   reg [23:0] lowCnt_r;
   reg [23:0] quietCnt_r;
   reg        riseQ_r;
   reg        fallQ_r;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // saturating run of transmit low
   always @(posedge clk) begin
      if (!rst_n || txdIn)
         lowCnt_r <= 24'h0;
      else if (lowCnt_r != 24'hffffff)
         lowCnt_r <= lowCnt_r + 24'h1;
   end

   // cycles of armed watchdog with no trigger edge; sync margin allowed
   always @(posedge clk) begin
      riseQ_r <= trigger_rise_in;
      fallQ_r <= trigger_fall_in;
      if (!rst_n || !wdActive || !nresOut_n ||
          (trigger_rise_in && !riseQ_r) || (!trigger_fall_in && fallQ_r))
         quietCnt_r <= 24'h0;
      else if (quietCnt_r != 24'hffffff)
         quietCnt_r <= quietCnt_r + 24'h1;
   end

   rec_idle_a: assert property (txdIn [*8] |-> !busDrive)
      else $error("bus dominant with transmit high");
   dom_limit_a: assert property (lowCnt_r > TXDOM_CYC + 24'h8 |-> !busDrive)
      else $error("bus still dominant after timeout");
   debug_wd_a: assert property (debugSel [*6] |-> !wdActive)
      else $error("watchdog on in debug");
   silent_outs_a: assert property (regLowTol |-> regOn && !termOn && !busDrive)
      else $error("silent outputs wrong");
   sleep_outs_a: assert property (!regOn |-> !nresOut_n && !rxdOut && !wdActive)
      else $error("sleep outputs wrong");
   wake_clear_a: assert property ((enPin && nresOut_n) [*8] |-> txdOe_n && !txdWeakPd)
      else $error("wake source not cleared");
   reset_hold_a: assert property ($rose(regOn) |-> !nresOut_n [*8])
      else $error("reset released too early");
   under_rst_a: assert property (vddUnder [*6] |-> !nresOut_n)
      else $error("no reset on undervoltage");
   wd_starve_a: assert property (quietCnt_r <= LEAD_CYC + 24'h8)
      else $error("missing trigger gave no reset");

   cover property ($rose(regLowTol));
   cover property ($fell(txdOe_n));
   cover property ($rose(txdWeakPd));
endmodule // lsmc_mode_ctrl_properties

/* File: tb/lsmc_host_model.sv */
// host microcontroller model driving enable, transmit and triggers
`timescale 1ns/1ps
module lsmc_host_model (
   input  wire clk,
   output reg  enPin,
   output reg  txdIn,
   output reg  trigger_rise_in,
   output reg  trigger_fall_in
);
   reg       trigOn;
   reg [4:0] trigCnt;

   initial begin
      enPin = 1'h0;
      txdIn = 1'h1;
      trigger_rise_in = 1'h0;
      trigger_fall_in = 1'h1;
      trigOn = 1'h0;
      trigCnt = 5'h00;
   end

   // both pins in one write, level kept past the window
   task setMode(input logic en, input logic txd);
      @(posedge clk);
      enPin <= en;
      txdIn <= txd;
   endtask

   task trig(input logic on);
      @(posedge clk);
      trigOn <= on;
   endtask

   // one trigger edge every 64 cycles (pins toggle every 32), well inside the period
   always @(posedge clk) begin
      if (trigOn) begin
         trigCnt <= trigCnt + 5'h01;
         if (trigCnt == 5'h00) begin
            trigger_rise_in <= ~trigger_rise_in;
            trigger_fall_in <= ~trigger_fall_in;
         end
      end
   end
endmodule // lsmc_host_model

/* File: tb/lsmc_mode_ctrl_tb_top.sv */
// self-checking bench of the mode controller
`timescale 1ns/1ps
module lsmc_mode_ctrl_tb_top;
   localparam [5:0]  PRE = 6'h02;
   localparam [5:0]  NORM = 6'h04;
   localparam [5:0]  SIL = 6'h10;
   localparam [5:0]  SLP = 6'h20;
   localparam [32:0] MODE_M = 33'h1_0000_003f;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        enPin, txdIn, txdOut, txdOe_n, txdWeakPd, busRx, busDrive;
   logic        rxdOut, wakePin_n, debugSel, trigger_rise_in, trigger_fall_in;
   logic        vsPowerOk, vddUnder, nresOut_n, regOn, regLowTol, termOn;
   logic        wdActive, t, b;
   logic [65:0] ent;
   logic [65:0] entA;
   logic [65:0] expQ[$];
   int          miscompares;
   int          comparisons;
   event        pinEv;
   wire  [7:0]  obs = {nresOut_n, rxdOut, regOn, busDrive, txdWeakPd,
                       txdOe_n, wdActive, termOn};

   // short counts keep the run brief
   localparam [23:0] RESET_CYC = 24'h000032;
   localparam [23:0] TXDOM_CYC = 24'h000028;
   localparam [23:0] LEAD_CYC  = 24'h0000c8;
   localparam [23:0] WDPER_CYC = 24'h000064;
   localparam [23:0] NRESP_CYC = 24'h00000a;
   localparam [23:0] WAKE_CYC  = 24'h000014;
   lsmc_mode_ctrl #(
      .RESET_CYC (RESET_CYC),
      .TXDOM_CYC (TXDOM_CYC),
      .LEAD_CYC  (LEAD_CYC),
      .WDPER_CYC (WDPER_CYC),
      .NRESP_CYC (NRESP_CYC),
      .BUSWK_CYC (WAKE_CYC),
      .LOCWK_CYC (WAKE_CYC)
   ) i_lsmc_mode_ctrl (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .enPin(enPin), .txdIn(txdIn),
      .txdOut(txdOut), .txdOe_n(txdOe_n), .txdWeakPd(txdWeakPd),
      .busRx(busRx), .busDrive(busDrive), .rxdOut(rxdOut),
      .wakePin_n(wakePin_n), .debugSel(debugSel),
      .trigger_rise_in(trigger_rise_in), .trigger_fall_in(trigger_fall_in),
      .vsPowerOk(vsPowerOk), .vddUnder(vddUnder), .nresOut_n(nresOut_n),
      .regOn(regOn), .regLowTol(regLowTol), .termOn(termOn),
      .wdActive(wdActive));
   lsmc_host_model i_lsmc_host_model (.clk(clk), .enPin(enPin),
      .txdIn(txdIn), .trigger_rise_in(trigger_rise_in),
      .trigger_fall_in(trigger_fall_in));

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   task results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task check(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   // the watcher samples at the next falling edge
   task pin(input logic [7:0] m, input logic [7:0] e);
      expQ.push_back({25'h0, m, 25'h0, e});
      ->pinEv;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [32:0] m, input logic [32:0] e);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         expQ.push_back({m, e});
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task mode(input logic [5:0] md);
      apb(1'h0, 12'h004, 32'h0, MODE_M, {27'h0, md});
   endtask

   // outputs are settled half a cycle after the launching edge
   always @(pinEv) begin
      @(negedge clk);
      ent = expQ.pop_front();
      check({25'h0, obs} & ent[65:33], ent[32:0]);
   end

   always @(posedge clk) begin
      if (psel && penable && !pwrite && pready) begin
         entA = expQ.pop_front();
         check({pslverr, prdata} & entA[65:33], entA[32:0]);
      end
   end

   // hang guard, far beyond the expected run
   initial begin
      #200000;
      miscompares++;
      results();
   end

   initial begin
      void'($urandom(13003));
      rst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      busRx = 1'h1;
      wakePin_n = 1'h1;
      debugSel = 1'h0;
      vsPowerOk = 1'h1;
      vddUnder = 1'h0;
      miscompares = 0;
      comparisons = 0;
      wt(2);
      rst_n <= 1'h1;
      i_lsmc_host_model.trig(1'h1);
      wt(10);
      pin(8'ha0, 8'h20);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      wt(5);
      i_lsmc_host_model.setMode(1'h0, 1'h1);
      wt(5);
      mode(PRE);
      wt(60);
      mode(PRE);
      pin(8'h80, 8'h80);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      wt(8);
      mode(NORM);
      for (int i = 0; i < 8; i++) begin
         t = 1'($urandom);
         b = 1'($urandom);
         i_lsmc_host_model.setMode(1'h1, t);
         busRx <= b;
         wt(8);
         pin(8'h50, {1'h0, b, 1'h0, ~t, 4'h0});
         // short high gap keeps random low runs under the time-out
         i_lsmc_host_model.setMode(1'h1, 1'h1);
         wt(3);
      end
      busRx <= 1'h1;
      i_lsmc_host_model.setMode(1'h1, 1'h0);
      wt(10);
      pin(8'h10, 8'h10);
      wt(50);
      pin(8'h10, 8'h00);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      apb(1'h0, 12'h000, 32'h0, 33'h1_0000_0003, 33'h3);
      apb(1'h1, 12'h004, $urandom, 33'h0, 33'h0);
      mode(NORM);
      apb(1'h0, 12'h010, 32'h0, 33'h1_ffff_ffff, 33'h1_0000_0000);
      debugSel <= 1'h1;
      wt(8);
      pin(8'h02, 8'h00);
      debugSel <= 1'h0;
      wt(8);
      pin(8'h02, 8'h02);
      i_lsmc_host_model.trig(1'h0);
      for (int n = 0; n < 300 && nresOut_n !== 1'h0; n++) wt(1);
      pin(8'h80, 8'h00);
      i_lsmc_host_model.trig(1'h1);
      wt(20);
      i_lsmc_host_model.setMode(1'h0, 1'h1);
      wt(200);
      mode(SIL);
      pin(8'ha3, 8'ha0);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      wt(8);
      mode(NORM);
      i_lsmc_host_model.setMode(1'h0, 1'h1);
      wt(200);
      busRx <= 1'h0;
      wt(30);
      busRx <= 1'h1;
      wt(5);
      mode(PRE);
      pin(8'h4c, 8'h0c);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      wt(8);
      pin(8'h4c, 8'h44);
      mode(NORM);
      i_lsmc_host_model.setMode(1'h0, 1'h1);
      wt(200);
      pin(8'h80, 8'h80);
      vddUnder <= 1'h1;
      wt(10);
      vddUnder <= 1'h0;
      pin(8'h80, 8'h00);
      mode(PRE);
      wt(60);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      wt(8);
      mode(NORM);
      i_lsmc_host_model.setMode(1'h0, 1'h0);
      wt(200);
      mode(SLP);
      pin(8'he2, 8'h00);
      i_lsmc_host_model.setMode(1'h1, 1'h0);
      wt(20);
      mode(SLP);
      i_lsmc_host_model.setMode(1'h0, 1'h1);
      wakePin_n <= 1'h0;
      wt(30);
      wakePin_n <= 1'h1;
      wt(5);
      mode(PRE);
      pin(8'h65, 8'h21);
      wt(60);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      wt(8);
      mode(NORM);
      i_lsmc_host_model.setMode(1'h0, 1'h0);
      wt(200);
      vsPowerOk <= 1'h0;
      wt(10);
      vsPowerOk <= 1'h1;
      wt(10);
      mode(PRE);
      // host not supplied, local wake disabled
      apb(1'h1, 12'h000, 32'h0, 33'h0, 33'h0);
      apb(1'h0, 12'h000, 32'h0, 33'h1_0000_0003, 33'h0);
      wt(40);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      wt(8);
      mode(NORM);
      i_lsmc_host_model.setMode(1'h0, 1'h0);
      wt(200);
      mode(SLP);
      wakePin_n <= 1'h0;
      wt(30);
      wakePin_n <= 1'h1;
      wt(5);
      mode(SLP);
      i_lsmc_host_model.setMode(1'h1, 1'h1);
      wt(8);
      mode(NORM);
      pin(8'h20, 8'h20);
      wt(5);
      results();
   end
endmodule // lsmc_mode_ctrl_tb_top

bind lsmc_mode_ctrl lsmc_mode_ctrl_properties #(
   .TXDOM_CYC(TXDOM_CYC),
   .LEAD_CYC(LEAD_CYC)
) i_lsmc_mode_ctrl_properties (
   .clk, .rst_n, .enPin, .txdIn, .txdOe_n, .txdWeakPd, .busDrive, .rxdOut,
   .debugSel, .trigger_rise_in, .trigger_fall_in, .vddUnder, .nresOut_n,
   .regOn, .regLowTol, .termOn, .wdActive);
